// *** src/uep_defines.vh ***
// Constants for the UV EPROM programmer/host controller
`ifndef UEP_DEFINES_VH
`define UEP_DEFINES_VH
`define UEP_ADDR_W        19
`define UEP_DATA_W        8
`define UEP_MAX_TRIES     4'hA
`define UEP_PULSE_NS      100000
`define UEP_CLK_NS        10
`define UEP_PULSE_CYC     (`UEP_PULSE_NS / `UEP_CLK_NS)
`define UEP_SETUP_CYC     16'h0004
`define UEP_SETTLE_CYC    16'h0008
`define UEP_ERASED_BYTE   8'hFF
`endif

// *** src/uep_host.v ***
// Host controller that reads, programs and verifies a UV EPROM over its pins
// Functional notes
// - Program: raise supply, chip select high, gate high, present byte.
// - Hold address and data stable, pulse chip select low one pulse width.
// - First pass pulses every location exactly once before verify phase.
// - Verify with select high, gate low; on mismatch raise gate, then pulse.
// - At most ten verify-pulse iterations per word, then report failure.
// - Final pass verifies every byte with supplies back at read level.
// - In identifier mode other address lines low, select and gate low.
`timescale 1ns/10ps
`include "uep_defines.vh"

module uep_host #(
	parameter PULSE_CYC = `UEP_PULSE_CYC
) (
	// Clock and reset
	input  wire                    clock,
	input  wire                    resetn,
	// Command side
	input  wire                    cmd_read,
	input  wire                    cmd_ident,
	input  wire                    cmd_prog,
	input  wire [`UEP_ADDR_W-1:0]  cmd_addr,
	input  wire [`UEP_ADDR_W-1:0]  cmd_last,
	output wire                    cmd_ready,
	output reg  [`UEP_DATA_W-1:0]  rd_data,
	output reg                     rd_valid,
	output reg                     prog_done,
	output reg                     prog_fail,
	// Image source, same clock, combinational lookup by address
	output wire [`UEP_ADDR_W-1:0]  img_addr,
	input  wire [`UEP_DATA_W-1:0]  img_data,
	// Device pins
	output reg  [`UEP_ADDR_W-1:0]  mem_addr,
	output reg                     chip_sel_n,
	output reg                     out_gate_n,
	output reg                     prog_supply_hi,
	output reg                     identifier_high_voltage,
	input  wire [`UEP_DATA_W-1:0]  data_lines_i,
	output reg  [`UEP_DATA_W-1:0]  data_lines_o,
	output reg                     data_lines_oe
);

	localparam [3:0] S_IDLE  = 4'h0;
	localparam [3:0] S_RSET  = 4'h1;
	localparam [3:0] S_RCAP  = 4'h2;
	localparam [3:0] S_PSET  = 4'h3;
	localparam [3:0] S_PPUL  = 4'h4;
	localparam [3:0] S_PHLD  = 4'h5;
	localparam [3:0] S_VSET  = 4'h6;
	localparam [3:0] S_VCHK  = 4'h7;
	localparam [3:0] S_FSET  = 4'h8;
	localparam [3:0] S_FCHK  = 4'h9;
	localparam [3:0] S_PDONE = 4'hA;

	localparam [1:0] PH_FIRST = 2'h0;
	localparam [1:0] PH_VER   = 2'h1;
	localparam [1:0] PH_FINAL = 2'h2;

	reg [3:0]             state_r;
	reg [1:0]             phase_r;
	reg [15:0]            cnt_r;
	reg [3:0]             tries_r;
	reg [`UEP_ADDR_W-1:0] first_r;
	reg [`UEP_ADDR_W-1:0] last_r;
	reg                   ident_r;
	reg [`UEP_DATA_W-1:0] sync1_r;
	reg [`UEP_DATA_W-1:0] sync2_r;
	reg [`UEP_DATA_W-1:0] sync3_r;

	// Sampled bus: accepted only when last two stages agree
	wire                   rd_stable = (sync2_r == sync3_r);
	wire [`UEP_ADDR_W-1:0] next_addr = mem_addr + {{(`UEP_ADDR_W-1){1'b0}}, 1'b1};
	wire                   at_last   = (mem_addr == last_r);
	// Select falls on the first pulse edge, so the count must reach the
	// full width before release; one less would leave a short pulse
	wire [15:0]            pulse_lim = PULSE_CYC[15:0] + 16'h0001;

	assign cmd_ready = (state_r == S_IDLE);
	assign img_addr  = mem_addr;

	// Returns true when a count has elapsed
	function cnt_done;
		input [15:0] c;
		input [15:0] lim;
		begin
			cnt_done = (c >= lim - 16'h0001);
		end
	endfunction

	// Three-stage synchroniser on the data lines
	always @(posedge clock) begin
		sync1_r <= data_lines_i;
		sync2_r <= sync1_r;
		sync3_r <= sync2_r;
	end

	// Main sequencer
	always @(posedge clock) begin
		if (!resetn) begin
			state_r                 <= S_IDLE;
			phase_r                 <= PH_FIRST;
			cnt_r                   <= 16'h0000;
			tries_r                 <= 4'h0;
			first_r                 <= {`UEP_ADDR_W{1'b0}};
			last_r                  <= {`UEP_ADDR_W{1'b0}};
			ident_r                 <= 1'b0;
			mem_addr                <= {`UEP_ADDR_W{1'b0}};
			chip_sel_n              <= 1'b1;
			out_gate_n              <= 1'b1;
			prog_supply_hi          <= 1'b0;
			identifier_high_voltage <= 1'b0;
			data_lines_o            <= `UEP_ERASED_BYTE;
			data_lines_oe           <= 1'b0;
			rd_data                 <= 8'h00;
			rd_valid                <= 1'b0;
			prog_done               <= 1'b0;
			prog_fail               <= 1'b0;
		end else begin
			rd_valid  <= 1'b0;
			prog_done <= 1'b0;
			prog_fail <= 1'b0;
			cnt_r     <= cnt_r + 16'h0001;
			case (state_r)
			S_IDLE: begin
				cnt_r <= 16'h0000;
				// Idle parks in standby so the shared bus stays free
				chip_sel_n    <= 1'b1;
				out_gate_n    <= 1'b1;
				data_lines_oe <= 1'b0;
				identifier_high_voltage <= 1'b0;
				prog_supply_hi <= 1'b0;
				if (cmd_prog) begin
					first_r    <= cmd_addr;
					last_r     <= cmd_last;
					mem_addr   <= cmd_addr;
					phase_r    <= PH_FIRST;
					prog_supply_hi <= 1'b1;
					state_r    <= S_PSET;
				end else if (cmd_read || cmd_ident) begin
					ident_r <= cmd_ident;
					// Identifier read keeps all other lines low
					mem_addr <= cmd_ident ?
						{{(`UEP_ADDR_W-1){1'b0}}, cmd_addr[0]} :
						cmd_addr;
					identifier_high_voltage <= cmd_ident;
					state_r  <= S_RSET;
				end
			end
			S_RSET: begin
				// Select and gate low drive read data out
				chip_sel_n <= 1'b0;
				out_gate_n <= 1'b0;
				if (cnt_done(cnt_r, `UEP_SETTLE_CYC)) begin
					cnt_r   <= 16'h0000;
					state_r <= S_RCAP;
				end
			end
			S_RCAP: begin
				if (rd_stable) begin
					rd_data    <= sync3_r;
					rd_valid   <= 1'b1;
					// Drop the identifier level with select, not after
					identifier_high_voltage <= 1'b0;
					chip_sel_n <= 1'b1;
					out_gate_n <= 1'b1;
					state_r    <= S_IDLE;
				end
			end
			S_PSET: begin
				// Gate high before driving, so device never fights us
				chip_sel_n    <= 1'b1;
				out_gate_n    <= 1'b1;
				data_lines_o  <= img_data;
				data_lines_oe <= 1'b1;
				if (cnt_done(cnt_r, `UEP_SETUP_CYC)) begin
					cnt_r   <= 16'h0000;
					state_r <= S_PPUL;
				end
			end
			S_PPUL: begin
				// Address and data frozen for the whole pulse
				chip_sel_n <= 1'b0;
				if (cnt_done(cnt_r, pulse_lim)) begin
					cnt_r      <= 16'h0000;
					chip_sel_n <= 1'b1;
					state_r    <= S_PHLD;
				end
			end
			S_PHLD: begin
				if (cnt_done(cnt_r, `UEP_SETUP_CYC)) begin
					cnt_r         <= 16'h0000;
					data_lines_oe <= 1'b0;
					if (phase_r == PH_FIRST) begin
						// One pulse per location before any verify
						if (at_last) begin
							phase_r  <= PH_VER;
							mem_addr <= first_r;
							tries_r  <= 4'h0;
							state_r  <= S_VSET;
						end else begin
							mem_addr <= next_addr;
							state_r  <= S_PSET;
						end
					end else begin
						state_r <= S_VSET;
					end
				end
			end
			S_VSET: begin
				// Verify at raised supply: select high, gate low
				chip_sel_n <= 1'b1;
				out_gate_n <= 1'b0;
				data_lines_oe <= 1'b0;
				if (cnt_done(cnt_r, `UEP_SETTLE_CYC)) begin
					cnt_r   <= 16'h0000;
					state_r <= S_VCHK;
				end
			end
			S_VCHK: begin
				if (rd_stable) begin
					out_gate_n <= 1'b1;
					cnt_r      <= 16'h0000;
					if (sync3_r == img_data) begin
						tries_r <= 4'h0;
						if (at_last) begin
							// Drop to read level before final pass
							prog_supply_hi <= 1'b0;
							phase_r  <= PH_FINAL;
							mem_addr <= first_r;
							state_r  <= S_FSET;
						end else begin
							mem_addr <= next_addr;
							state_r  <= S_VSET;
						end
					end else if (tries_r == `UEP_MAX_TRIES - 4'h1) begin
						// Ten strikes: give up on this word
						prog_fail <= 1'b1;
						state_r   <= S_IDLE;
					end else begin
						tries_r <= tries_r + 4'h1;
						state_r <= S_PSET;
					end
				end
			end
			S_FSET: begin
				chip_sel_n <= 1'b0;
				out_gate_n <= 1'b0;
				if (cnt_done(cnt_r, `UEP_SETTLE_CYC)) begin
					cnt_r   <= 16'h0000;
					state_r <= S_FCHK;
				end
			end
			S_FCHK: begin
				if (rd_stable) begin
					cnt_r <= 16'h0000;
					if (sync3_r != img_data) begin
						prog_fail <= 1'b1;
						state_r   <= S_IDLE;
					end else if (at_last) begin
						state_r <= S_PDONE;
					end else begin
						mem_addr <= next_addr;
						state_r  <= S_FSET;
					end
				end
			end
			S_PDONE: begin
				prog_done <= 1'b1;
				state_r   <= S_IDLE;
			end
			default: begin
				state_r <= S_IDLE;
			end
			endcase
		end
	end

endmodule // uep_host

// *** dv/uep_host_monitor.sv ***
// Pin-level checker for the EPROM host controller
`timescale 1ns/10ps
module uep_host_monitor #(
	parameter PULSE_CYC = 20
) (
	// Clock and reset
	input wire		clock,
	input wire		resetn,
	// Command side
	input wire		cmd_read,
	input wire		cmd_ident,
	input wire		cmd_ready,
	input wire		rd_valid,
	// Device pins
	input wire [18:0]	mem_addr,
	input wire		chip_sel_n,
	input wire		out_gate_n,
	input wire		prog_supply_hi,
	input wire		identifier_high_voltage,
	input wire		data_lines_oe
);
	reg [15:0]	low_r;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Cycles with select low; pulse width is judged at the rising edge
	always @(posedge clock)
		low_r <= chip_sel_n ? 16'h0000 : low_r + 16'h0001;
	idle_pins_a: assert property ($rose(resetn) |-> chip_sel_n
		&& out_gate_n && !data_lines_oe && !prog_supply_hi)
		else $error("pins busy after reset");
	no_clash_a: assert property (data_lines_oe |-> out_gate_n)
		else $error("host drives while gate low");
	prog_gate_a: assert property (
		prog_supply_hi && !chip_sel_n |-> out_gate_n)
		else $error("pulse with gate low");
	pulse_len_a: assert property (
		$rose(chip_sel_n) && prog_supply_hi |-> low_r == PULSE_CYC)
		else $error("wrong pulse width");
	setup_ok_a: assert property ($fell(chip_sel_n) && prog_supply_hi
		|-> $stable(mem_addr) && $past(data_lines_oe))
		else $error("no setup before pulse");
	ident_addr_a: assert property (identifier_high_voltage |->
		mem_addr[18:1] == 18'h00000 && !prog_supply_hi)
		else $error("identifier address not low");
	read_time_a: assert property (
		(cmd_read || cmd_ident) && cmd_ready |-> ##[8:30] rd_valid)
		else $error("read answer late");
	final_read_a: assert property (
		!chip_sel_n && !out_gate_n |-> !prog_supply_hi)
		else $error("read at raised supply");
endmodule // uep_host_monitor

bind uep_host uep_host_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (
	.clock(clock),
	.resetn(resetn),
	.cmd_read(cmd_read),
	.cmd_ident(cmd_ident),
	.cmd_ready(cmd_ready),
	.rd_valid(rd_valid),
	.mem_addr(mem_addr),
	.chip_sel_n(chip_sel_n),
	.out_gate_n(out_gate_n),
	.prog_supply_hi(prog_supply_hi),
	.identifier_high_voltage(identifier_high_voltage),
	.data_lines_oe(data_lines_oe)
);

// *** dv/uep_eprom_model.sv ***
// Behavioural UV EPROM answering the host's pins
`timescale 1ns/10ps
module uep_eprom_model #(
	parameter [7:0] MAKER_ID = 8'h3C, // Arbitrary value
	parameter [7:0] PART_ID  = 8'hA5  // Arbitrary value
) (
	// Pins from the host
	input  wire [18:0]	mem_addr,
	input  wire		chip_sel_n,
	input  wire		out_gate_n,
	input  wire		prog_supply_hi,
	input  wire		identifier_high_voltage,
	input  wire [7:0]	data_lines_o,
	input  wire		data_lines_oe,
	// Resolved bus and fault hook
	output wire [7:0]	data_lines_i,
	input  wire [18:0]	bad_addr,
	output reg  [7:0]	bad_hits
);
	reg [7:0]	mem [0:524287];
	reg [7:0]	last_r;
	integer		i;
	// Read at normal supply, verify at raised supply
	wire rd = !chip_sel_n && !out_gate_n && !prog_supply_hi;
	wire vf = chip_sel_n && !out_gate_n && prog_supply_hi;
	wire [7:0] id = mem_addr[0] ? PART_ID : MAKER_ID;
	wire [7:0] q = identifier_high_voltage ? id : mem[mem_addr];
	// Released bus shows the inverse of its last level, not a stale copy
	assign data_lines_i = data_lines_oe ? data_lines_o :
		(rd || vf) ? q : ~last_r;
	always @(data_lines_i)
		if (data_lines_oe || rd || vf)
			last_r = data_lines_i;
	// Erased array reads all ones
	initial begin
		// Released bus starts at zero, so an erased read must be driven
		last_r = 8'hFF;
		bad_hits = 8'h00;
		for (i = 0; i < 524288; i = i + 1)
			mem[i] = 8'hFF;
	end
	// Pulse end clears bits only; the bad word never takes
	always @(posedge chip_sel_n)
		if (prog_supply_hi && out_gate_n) begin
			if (mem_addr == bad_addr)
				bad_hits = bad_hits + 8'h01;
			else
				mem[mem_addr] = mem[mem_addr] & data_lines_o;
		end
endmodule // uep_eprom_model

// *** dv/uep_host_tb.sv ***
// Self-checking bench for the EPROM host controller
`timescale 1ns/10ps
module uep_host_tb;
	localparam [7:0] MK = 8'h3C; // Arbitrary value
	localparam [7:0] PT = 8'hA5; // Arbitrary value
	reg		clock, resetn, cmd_read, cmd_ident, cmd_prog;
	reg [18:0]	cmd_addr, cmd_last, bad_addr;
	wire		cmd_ready, rd_valid, prog_done, prog_fail;
	wire		chip_sel_n, out_gate_n, data_lines_oe;
	wire		prog_supply_hi, identifier_high_voltage;
	wire [18:0]	img_addr, mem_addr;
	wire [7:0]	rd_data, data_lines_i, data_lines_o, bad_hits;
	integer		fails = 0, n_tests = 0;
	// Image byte follows its address
	wire [7:0]	img_data = img_addr[7:0] ^ 8'h5A;
	uep_host #(.PULSE_CYC(20)) u_dut (
		.clock(clock), .resetn(resetn),
		.cmd_read(cmd_read), .cmd_ident(cmd_ident), .cmd_prog(cmd_prog),
		.cmd_addr(cmd_addr), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
		.rd_data(rd_data), .rd_valid(rd_valid),
		.prog_done(prog_done), .prog_fail(prog_fail),
		.img_addr(img_addr), .img_data(img_data),
		.mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
		.out_gate_n(out_gate_n), .prog_supply_hi(prog_supply_hi),
		.identifier_high_voltage(identifier_high_voltage),
		.data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
		.data_lines_oe(data_lines_oe)
	);
	uep_eprom_model #(.MAKER_ID(MK), .PART_ID(PT)) u_mem (
		.mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
		.out_gate_n(out_gate_n), .prog_supply_hi(prog_supply_hi),
		.identifier_high_voltage(identifier_high_voltage),
		.data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
		.data_lines_i(data_lines_i),
		.bad_addr(bad_addr), .bad_hits(bad_hits)
	);
	// Compare one result byte
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("mismatch %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Issue one command, then wait a bounded time for its answer
	task run(input [2:0] k, input [18:0] a, input [18:0] l);
		integer j;
		begin
			@(negedge clock);
			while (cmd_ready !== 1'b1)
				@(negedge clock);
			{cmd_prog, cmd_ident, cmd_read} = k;
			cmd_addr = a;
			cmd_last = l;
			@(negedge clock);
			{cmd_prog, cmd_ident, cmd_read} = 3'h0;
			j = 0;
			while (!(rd_valid || prog_done || prog_fail) && j < 9000) begin
				@(posedge clock);
				#1 j = j + 1;
			end
			if (j >= 9000)
				fails = fails + 1;
		end
	endtask
	// Idle pins and erased byte
	task t_erased;
		begin
			chk({chip_sel_n, out_gate_n, data_lines_oe, 5'h00}, 8'hC0);
			run(3'h1, 19'h00123, 19'h00000);
			chk(rd_data, 8'hFF);
		end
	endtask
	// Range wraps through the top address
	task t_program;
		begin
			run(3'h4, 19'h7FFFF, 19'h00001);
			chk({6'h00, prog_fail, prog_done}, 8'h01);
			run(3'h1, 19'h7FFFF, 19'h00000);
			chk(rd_data, 8'hA5);
			run(3'h1, 19'h00001, 19'h00000);
			chk(rd_data, 8'h5B);
		end
	endtask
	// Both identifier bytes
	task t_ident;
		begin
			run(3'h2, 19'h00000, 19'h00000);
			chk(rd_data, MK);
			run(3'h2, 19'h00001, 19'h00000);
			chk(rd_data, PT);
		end
	endtask
	// A word that never takes gets ten pulses, then fails
	task t_retry;
		begin
			bad_addr = 19'h00011;
			run(3'h4, 19'h00010, 19'h00012);
			chk({6'h00, prog_fail, prog_done}, 8'h02);
			chk(bad_hits, 8'h0A);
		end
	endtask
	// Print the counts and the verdict
	task wrap_up;
		begin
			$display("tests %0d fails %0d", n_tests, fails);
			if (fails == 0 && n_tests > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Watchdog well beyond the few hundred cycles the run needs
	initial begin
		#200000;
		fails = fails + 1;
		wrap_up;
	end
	// Reset, then the scenarios
	initial begin
		resetn = 1'b0;
		{cmd_prog, cmd_ident, cmd_read} = 3'h0;
		cmd_addr = 19'h00000;
		cmd_last = 19'h00000;
		bad_addr = 19'h40000;
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		t_erased;
		t_program;
		t_ident;
		t_retry;
		wrap_up;
	end
endmodule // uep_host_tb
